// File: sdp_pkg.sv
/*
 * sdp_pkg: shared constants for the subdivided duty pwm block.
 * assumes a single 100 MHz system clock and an AXI4-Lite register slave.
 */
package sdp_pkg;
	// ************************************************************
	// sizes
	// ************************************************************
	localparam int          SDP_CHANNELS    = 2;
	localparam int          SDP_DUTY_W      = 8;
	localparam int          SDP_ADDR_W      = 4;
	localparam logic [7:0]  SDP_CYCLE_LAST  = 8'h0_0FF;
	localparam logic [7:0]  SDP_SUB4_MASK   = 8'h0_03F;
	localparam logic [7:0]  SDP_SUB2_MASK   = 8'h0_07F;
	// ************************************************************
	// register map (byte offsets)
	// ************************************************************
	localparam logic [3:0]  SDP_OFF_DUTY0   = 4'h0;
	localparam logic [3:0]  SDP_OFF_DUTY1   = 4'h4;
	localparam logic [3:0]  SDP_OFF_CTRL    = 4'h8;
	localparam logic [3:0]  SDP_OFF_STAT    = 4'hC;
	// ************************************************************
	// control fields
	// ************************************************************
	localparam int          SDP_CTRL_EN0    = 0;
	localparam int          SDP_CTRL_EN1    = 1;
	localparam int          SDP_CTRL_MODE   = 4;
	localparam int          SDP_CTRL_GATE0  = 8;
	localparam int          SDP_CTRL_GATE1  = 9;
	localparam logic [31:0] SDP_CTRL_MASK   = 32'h0000_0313;
	localparam logic [31:0] SDP_CTRL_RESET  = 32'h0000_0000;
	localparam logic [7:0]  SDP_DUTY_RESET  = 8'h0_000;
	localparam logic [1:0]  SDP_RESP_OKAY   = 2'b00;
	localparam logic [1:0]  SDP_RESP_SLVERR = 2'b10;
endpackage

// File: sdp_cfg_if.sv
/*
 * sdp_cfg_if: carries live settings from the register file to the channels.
 * assumes one clock domain; purely wires.
 */
`timescale 1ns/1ps
interface sdp_cfg_if;
	logic [7:0] duty;
	logic       enable;
	logic       gate;
	logic       mode2;
	logic       cycleStart;
	logic [7:0] phase;
	logic       pwmOut;
	modport ctrl (output duty, output enable, output gate, output mode2,
		output cycleStart, output phase, input pwmOut);
	modport chan (input duty, input enable, input gate, input mode2,
		input cycleStart, input phase, output pwmOut);
endinterface

// File: sdp_channel.sv
/*
 * sdp_channel: one pwm channel, latching duty and mode at each full-cycle start.
 * assumes a shared free-running 8-bit phase counter from the parent.
 */
`timescale 1ns/1ps
module sdp_channel (
	// clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// settings and output
	sdp_cfg_if.chan   cfg
);
	import sdp_pkg::*;

	logic [7:0] duty_r, duty_nxt;
	logic       mode2_r, mode2_nxt;
	logic       out_r, out_nxt;
	logic [6:0] baseCnt;
	logic [1:0] spread;
	logic [1:0] subIdx;
	logic [6:0] subPos;
	logic [7:0] highCnt;

	// ************************************************************
	// waveform
	// ************************************************************
	always_comb begin
		duty_nxt  = duty_r;
		mode2_nxt = mode2_r;
		// latch only at full-cycle start so no cycle mixes patterns
		if (cfg.cycleStart) begin
			duty_nxt  = cfg.duty;
			mode2_nxt = cfg.mode2;
		end
		if (mode2_r) begin
			baseCnt = duty_r[7:1];
			spread  = {1'b0, duty_r[0]};
			subIdx  = {1'b0, cfg.phase[7]};
			subPos  = cfg.phase[6:0];
		end else begin
			baseCnt = {1'b0, duty_r[7:2]};
			spread  = duty_r[1:0];
			subIdx  = cfg.phase[7:6];
			subPos  = {1'b0, cfg.phase[5:0]};
		end
		// hardware splits duty itself
		highCnt = {1'b0, baseCnt} + ((subIdx < spread) ? 8'h0_001 : 8'h0_000);
		// high from the first clock of the sub-cycle for highCnt clocks
		out_nxt = ({1'b0, subPos} < highCnt);
		// control enable and gate bits both gate the pin
		out_nxt = out_nxt & cfg.enable & cfg.gate;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			duty_r  <= SDP_DUTY_RESET;
			mode2_r <= 1'b0;
			out_r   <= 1'b0;
		end else begin
			duty_r  <= duty_nxt;
			mode2_r <= mode2_nxt;
			out_r   <= out_nxt;
		end
	end

	assign cfg.pwmOut = out_r;
endmodule

// File: sdp_top.sv
/*
 * sdp_top: two-channel subdivided duty pwm with an AXI4-Lite register slave.
 * assumes a 100 MHz clock and a synchronous active-low reset; one access at a time.
 */
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps

module sdp_top (
	// clock and reset
	input  wire logic                           clk,
	input  wire logic                           resetn,
	// axi4-lite write address
	input  wire logic [sdp_pkg::SDP_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                     s_axi_awprot,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]                    s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	// axi4-lite read address
	input  wire logic [sdp_pkg::SDP_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                     s_axi_arprot,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                         s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	// pwm pins
	output logic [sdp_pkg::SDP_CHANNELS-1:0]    pwmOut
);
	import sdp_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	logic [7:0]  duty_r [SDP_CHANNELS];
	logic [7:0]  duty_nxt [SDP_CHANNELS];
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [7:0]  phase_r, phase_nxt;
	logic        awHeld_r, awHeld_nxt;
	logic        wHeld_r, wHeld_nxt;
	logic [3:0]  awAddr_r, awAddr_nxt;
	logic [31:0] wData_r, wData_nxt;
	logic [3:0]  wStrb_r, wStrb_nxt;
	logic        bValid_r, bValid_nxt;
	logic [1:0]  bResp_r, bResp_nxt;
	logic        rValid_r, rValid_nxt;
	logic [1:0]  rResp_r, rResp_nxt;
	logic [31:0] rData_r, rData_nxt;
	logic        doWrite;
	logic [31:0] wMerged;
	logic [31:0] rdWord;
	logic        rdHit;
	logic [SDP_CHANNELS-1:0] chanOut;

	// ************************************************************
	// phase counter
	// ************************************************************
	always_comb begin
		// one count per system clock, wraps every 256 clocks
		phase_nxt = phase_r + 8'h0_001;
	end

	// free running from reset, so every channel shares one cycle boundary
	always_ff @(posedge clk) begin
		if (!resetn) begin
			phase_r <= 8'h0_000;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	// ************************************************************
	// axi4-lite slave
	// ************************************************************
	// write happens when both halves are held and no response is pending
	assign doWrite = awHeld_r && wHeld_r && !bValid_r;

	always_comb begin
		wMerged = 32'h0000_0000;
		for (int b = 0; b < 4; b++) begin
			wMerged[b*8 +: 8] = wStrb_r[b] ? wData_r[b*8 +: 8] : 8'h0_000;
		end
	end

	always_comb begin
		rdWord = 32'h0000_0000;
		rdHit  = 1'b1;
		case (s_axi_araddr)
			SDP_OFF_DUTY0: rdWord = {24'h00_0000, duty_r[0]};
			SDP_OFF_DUTY1: rdWord = {24'h00_0000, duty_r[1]};
			SDP_OFF_CTRL:  rdWord = ctrl_r;
			// live pin state and phase for software to observe
			SDP_OFF_STAT:  rdWord = {22'h00_0000, chanOut, phase_r};
			default:       rdHit  = 1'b0;
		endcase
	end

	always_comb begin
		awHeld_nxt = awHeld_r;
		wHeld_nxt  = wHeld_r;
		awAddr_nxt = awAddr_r;
		wData_nxt  = wData_r;
		wStrb_nxt  = wStrb_r;
		bValid_nxt = bValid_r;
		bResp_nxt  = bResp_r;
		ctrl_nxt   = ctrl_r;
		for (int c = 0; c < SDP_CHANNELS; c++) begin
			duty_nxt[c] = duty_r[c];
		end
		if (s_axi_awvalid && s_axi_awready) begin
			awHeld_nxt = 1'b1;
			awAddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wHeld_nxt = 1'b1;
			wData_nxt = s_axi_wdata;
			wStrb_nxt = s_axi_wstrb;
		end
		if (doWrite) begin
			awHeld_nxt = 1'b0;
			wHeld_nxt  = 1'b0;
			bValid_nxt = 1'b1;
			bResp_nxt  = SDP_RESP_OKAY;
			case (awAddr_r)
				SDP_OFF_DUTY0: if (wStrb_r[0]) duty_nxt[0] = wData_r[7:0];
				SDP_OFF_DUTY1: if (wStrb_r[0]) duty_nxt[1] = wData_r[7:0];
				SDP_OFF_CTRL:  ctrl_nxt = ((ctrl_r & ~{{8{wStrb_r[3]}}, {8{wStrb_r[2]}},
					{8{wStrb_r[1]}}, {8{wStrb_r[0]}}}) | wMerged) & SDP_CTRL_MASK;
				SDP_OFF_STAT:  bResp_nxt = SDP_RESP_OKAY;
				default:       bResp_nxt = SDP_RESP_SLVERR;
			endcase
		end
		if (bValid_r && s_axi_bready) begin
			bValid_nxt = 1'b0;
		end
	end

	// read path: one address at a time, data snapshot taken at acceptance
	always_comb begin
		rValid_nxt = rValid_r;
		rResp_nxt  = rResp_r;
		rData_nxt  = rData_r;
		if (s_axi_arvalid && s_axi_arready) begin
			rValid_nxt = 1'b1;
			rData_nxt  = rdWord;
			rResp_nxt  = rdHit ? SDP_RESP_OKAY : SDP_RESP_SLVERR;
		end else if (rValid_r && s_axi_rready) begin
			rValid_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rValid_r <= 1'b0;
			rResp_r  <= SDP_RESP_OKAY;
			rData_r  <= 32'h0000_0000;
		end else begin
			rValid_r <= rValid_nxt;
			rResp_r  <= rResp_nxt;
			rData_r  <= rData_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctrl_r   <= SDP_CTRL_RESET;
			awHeld_r <= 1'b0;
			wHeld_r  <= 1'b0;
			awAddr_r <= 4'h0;
			wData_r  <= 32'h0000_0000;
			wStrb_r  <= 4'h0;
			bValid_r <= 1'b0;
			bResp_r  <= SDP_RESP_OKAY;
			for (int c = 0; c < SDP_CHANNELS; c++) begin
				duty_r[c] <= SDP_DUTY_RESET;
			end
		end else begin
			ctrl_r   <= ctrl_nxt;
			awHeld_r <= awHeld_nxt;
			wHeld_r  <= wHeld_nxt;
			awAddr_r <= awAddr_nxt;
			wData_r  <= wData_nxt;
			wStrb_r  <= wStrb_nxt;
			bValid_r <= bValid_nxt;
			bResp_r  <= bResp_nxt;
			for (int c = 0; c < SDP_CHANNELS; c++) begin
				duty_r[c] <= duty_nxt[c];
			end
		end
	end

	// a held half blocks a second one until the write retires
	assign s_axi_awready = !awHeld_r;
	assign s_axi_wready  = !wHeld_r;
	assign s_axi_bvalid  = bValid_r;
	assign s_axi_bresp   = bResp_r;
	assign s_axi_arready = !rValid_r;
	assign s_axi_rvalid  = rValid_r;
	assign s_axi_rdata   = rData_r;
	assign s_axi_rresp   = rResp_r;

	// ************************************************************
	// channels
	// ************************************************************
	generate
		for (genvar g = 0; g < SDP_CHANNELS; g++) begin : gChan
			sdp_cfg_if cfgBus ();
			assign cfgBus.duty       = duty_r[g];
			assign cfgBus.enable     = ctrl_r[SDP_CTRL_EN0 + g];
			assign cfgBus.gate       = ctrl_r[SDP_CTRL_GATE0 + g];
			assign cfgBus.mode2      = ctrl_r[SDP_CTRL_MODE];
			assign cfgBus.cycleStart = (phase_r == SDP_CYCLE_LAST);
			assign cfgBus.phase      = phase_r;
			assign chanOut[g]        = cfgBus.pwmOut;
			sdp_channel uChan (
				.clk    (clk),
				.resetn (resetn),
				.cfg    (cfgBus.chan)
			);
		end
	endgenerate

	assign pwmOut = chanOut;
endmodule

// File: sdp_top_chk.sv
/* sdp_top_chk: bus handshake and pin checks on the sdp_top ports.
 * assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module sdp_top_chk (
	// clock and reset
	input wire logic                             clk,
	input wire logic                             resetn,
	// bus
	input wire logic                             s_axi_awvalid,
	input wire logic                             s_axi_awready,
	input wire logic                             s_axi_wvalid,
	input wire logic                             s_axi_wready,
	input wire logic [1:0]                       s_axi_bresp,
	input wire logic                             s_axi_bvalid,
	input wire logic                             s_axi_bready,
	input wire logic                             s_axi_arvalid,
	input wire logic                             s_axi_arready,
	input wire logic [31:0]                      s_axi_rdata,
	input wire logic [1:0]                       s_axi_rresp,
	input wire logic                             s_axi_rvalid,
	input wire logic                             s_axi_rready,
	// pins
	input wire logic [sdp_pkg::SDP_CHANNELS-1:0] pwmOut
);
	import sdp_pkg::*;
	// ****************
	// checks
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	a_b_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer not retired");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped early");
	a_r_retire: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not retired");
	a_ar_block: assert property (s_axi_arready != s_axi_rvalid)
		else $error("read address ready wrong");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	// halves are held one clock, the write retires the next, then bvalid shows
	a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready && !s_axi_bvalid |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	a_pins_reset: assert property (disable iff (1'b0) !resetn |=> pwmOut == '0)
		else $error("pin high after reset");
endmodule
bind sdp_top sdp_top_chk i_chk (.clk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwmOut);

// File: tb_top.sv
/* tb_top: register and waveform tests for sdp_top.
 * assumes sdp_top alone, driven over its bus by this bench. */
`timescale 1ns/1ps
module tb_top;
	import sdp_pkg::*;
	logic        clk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
	logic [3:0]  awaddr = 0, araddr = 0, wstrb = 0;
	logic [31:0] wdata = 0, rdata;
	logic [1:0]  bresp, rresp, pwmOut;
	logic [33:0] rdQ[$];
	logic [1:0]  wrQ[$];
	logic [7:0]  seed = 8'h32, d;
	logic [7:0]  fix[4] = '{8'h00, 8'h01, 8'h05, 8'hFF};
	int          mismatches = 0, check_count = 0, i, cyc = 0;
	sdp_top i_dut (.clk, .resetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'b000),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'b000), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwmOut);
	// ****************
	// helpers
	// ****************
	initial forever #5 clk = ~clk;
	// clocks since reset release; the full pwm cycle starts with it
	always @(posedge clk) cyc <= resetn ? cyc + 1 : 0;
	function automatic logic [7:0] lfsr(logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic wrap_up;
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic tally(logic bad, string what);
		check_count++;
		if (bad) begin
			mismatches++;
			$display("BAD %0t %s", $time, what);
		end
	endtask
	task automatic cmpRd(logic [33:0] got, logic [33:0] exp);
		tally(got !== exp, $sformatf("read got %h expected %h", got, exp));
	endtask
	task automatic cmpWr(logic [1:0] got, logic [1:0] exp);
		tally(got !== exp, $sformatf("write resp got %h expected %h", got, exp));
	endtask
	task automatic cmpPin(logic [8:0] got, logic [8:0] exp);
		tally(got !== exp, $sformatf("pin highs got %0d expected %0d", got, exp));
	endtask
	task automatic stall;
		mismatches++;
		$display("BAD %0t no answer", $time);
		wrap_up;
	endtask
	// bus master: both halves offered together, each dropped when taken
	task automatic wr(logic [3:0] a, logic [31:0] v, logic [3:0] s, logic [1:0] r);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		wrQ.push_back(r);
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) break;
		end
		bready <= 0;
		if (n == 50) stall;
	endtask
	task automatic rd(logic [3:0] a, logic [31:0] v, logic [1:0] r);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		rdQ.push_back({r, v});
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) break;
		end
		rready <= 0;
		if (n == 50) stall;
	endtask
	always @(posedge clk) begin
		if (rvalid && rready) cmpRd({rresp, rdata}, rdQ.pop_front());
		if (bvalid && bready) cmpWr(bresp, wrQ.pop_front());
	end
	// high clocks per sub-cycle, window aligned to the start of a full cycle
	task automatic pwm(int ch, logic m2, logic [7:0] v, logic g, logic en);
		int n, k, sub, ns;
		logic [8:0] cnt[4], e[4];
		wr(ch ? SDP_OFF_DUTY1 : SDP_OFF_DUTY0, {24'h0000_00, v}, 4'hF, SDP_RESP_OKAY);
		wr(SDP_OFF_CTRL, (32'(m2) << SDP_CTRL_MODE) | (32'(g) << (SDP_CTRL_GATE0 + ch))
			| (32'(en) << (SDP_CTRL_EN0 + ch)), 4'hF, SDP_RESP_OKAY);
		repeat (520) @(posedge clk);
		sub = m2 ? 128 : 64;
		ns = 256 / sub;
		for (k = 0; k < 4; k++) begin
			cnt[k] = 9'h000;
			e[k] = (k >= ns || !g || !en) ? 9'h000
				: (m2 ? v[7:1] + (k < v[0]) : v[7:2] + (k < v[1:0]));
		end
		// the pin lags the phase by one clock: phase 0 is seen at cyc mod 256 == 1
		for (n = 0; n < 300; n++) begin
			@(posedge clk);
			if (cyc % 256 == 1) break;
		end
		if (n == 300) stall;
		// an unknown pin turns the count unknown, which the compare catches
		for (k = 0; k < 256; k++) begin
			cnt[k / sub] += 9'(pwmOut[ch]);
			@(posedge clk);
		end
		for (k = 0; k < 4; k++) cmpPin(cnt[k], e[k]);
	endtask
	// ****************
	// sequence
	// ****************
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1;
		rd(SDP_OFF_DUTY0, 32'h0000_0000, SDP_RESP_OKAY);
		rd(SDP_OFF_CTRL, SDP_CTRL_RESET, SDP_RESP_OKAY);
		wr(SDP_OFF_CTRL, 32'hFFFF_FFFF, 4'hF, SDP_RESP_OKAY);
		rd(SDP_OFF_CTRL, SDP_CTRL_MASK, SDP_RESP_OKAY);
		wr(SDP_OFF_DUTY1, 32'h0000_00A5, 4'hF, SDP_RESP_OKAY);
		wr(SDP_OFF_DUTY1, 32'h0000_0011, 4'hE, SDP_RESP_OKAY);
		rd(SDP_OFF_DUTY1, 32'h0000_00A5, SDP_RESP_OKAY);
		wr(4'h2, 32'h0000_00FF, 4'hF, SDP_RESP_SLVERR);
		rd(4'h2, 32'h0000_0000, SDP_RESP_SLVERR);
		for (i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			d = (i < 8) ? fix[i % 4] : seed;
			pwm(i / 4 % 2, i[0], d, i != 11, i != 10);
		end
		wrap_up;
	end
endmodule
